/* core/dwc_regs.sv */
// AXI4-Lite register bank holding the display update window rectangle.

// Summary of operation
// - X start is ten bits: low byte in one register, bits 9-8 in next.
// - Y start is ten bits, split low byte and two-bit high register, first row.
// - Y end is ten bits: low byte in one register, bits 9-8 in next.
// - All coordinates count from the displayed image's top left, rotation notwithstanding.
// - All window registers are readable, writable and clear to zero on reset.
module dwc_regs (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [dwc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [dwc_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  output dwc_pkg::dwc_window_s            window,
  output logic                            window_ok
);

  // ----------------------------------------------------------------------
  // Address decoding.
  // ----------------------------------------------------------------------

  // Maps a byte address to a store slot; bit SLOT_W flags a hit.
  function automatic logic [dwc_pkg::SLOT_W:0] decode(input logic [dwc_pkg::ADDR_W-1:0] a);
    logic [dwc_pkg::ADDR_W-1:0] base;
    logic [dwc_pkg::ADDR_W-1:0] off;
    base = dwc_pkg::ADDR_W'({dwc_pkg::IDX_X_START_LOW, 2'b00});
    off  = a - base;
    decode = '0;
    if (a[1:0] == 2'b00 && a >= base && off[2:0] == 3'b000 &&
        off[dwc_pkg::ADDR_W-1:3] < (dwc_pkg::ADDR_W-3)'(dwc_pkg::SLOT_N)) begin
      decode = {1'b1, off[3 +: dwc_pkg::SLOT_W]};
    end
  endfunction

  // Status sits at an address of its own, outside the slot range.
  function automatic logic is_status(input logic [dwc_pkg::ADDR_W-1:0] a);
    is_status = (a == dwc_pkg::ADDR_W'({dwc_pkg::IDX_STATUS, 2'b00}));
  endfunction

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  dwc_pkg::dwc_wr_e            wr_state;
  dwc_pkg::dwc_rd_e            rd_state;
  logic                        aw_held;
  logic                        w_held;
  logic [dwc_pkg::ADDR_W-1:0]  wr_addr;
  logic [7:0]                  wr_byte;
  logic                        wr_lane0;
  logic [dwc_pkg::ADDR_W-1:0]  rd_addr;
  logic [7:0]                  store_rd;
  logic [dwc_pkg::SLOT_N*8-1:0] contents;
  logic [1:0]                  status;

  // Handshakes and decode results as named wires.
  wire logic                    aw_take  = awvalid && awready;
  wire logic                    w_take   = wvalid && wready;
  wire logic                    ar_take  = arvalid && arready;
  wire logic [dwc_pkg::SLOT_W:0] wr_dec  = decode(wr_addr);
  wire logic [dwc_pkg::SLOT_W:0] rd_dec  = decode(rd_addr);
  wire logic [dwc_pkg::SLOT_W:0] ar_dec  = decode(araddr);
  wire logic                    wr_fire  = (wr_state == dwc_pkg::WR_COLLECT) && aw_held && w_held;
  wire logic                    wr_hit   = wr_dec[dwc_pkg::SLOT_W];
  wire logic                    wr_stat  = is_status(wr_addr);
  wire logic                    rd_hit   = rd_dec[dwc_pkg::SLOT_W];
  wire logic                    rd_stat  = is_status(rd_addr);

  // Odd slots are the high halves; only bits 1-0 exist there, the rest read zero.
  wire logic                    wr_high  = wr_dec[0];
  wire logic [7:0]              wr_value = wr_high ? (wr_byte & dwc_pkg::HIGH_MASK) : wr_byte;
  wire logic                    store_we = wr_fire && wr_hit && wr_lane0;

  // Store slots in register order: xs lo, xs hi, ys lo, ys hi, xe lo, xe hi, ye lo, ye hi.
  dwc_store #(
    .SLOT_N (dwc_pkg::SLOT_N),
    .SLOT_W (dwc_pkg::SLOT_W),
    .DATA_W (dwc_pkg::LOW_W)
  ) u_store (
    .clk      (clk),
    .nrst     (nrst),
    .wr_en    (store_we),
    .wr_slot  (wr_dec[dwc_pkg::SLOT_W-1:0]),
    .wr_data  (wr_value),
    .rd_slot  (ar_dec[dwc_pkg::SLOT_W-1:0]),
    .rd_data  (store_rd),
    .contents (contents)
  );

  // ----------------------------------------------------------------------
  // Coordinate assembly: ten bits from a low byte and two high bits.
  // ----------------------------------------------------------------------
  wire dwc_pkg::dwc_window_s next_window = '{
    x_start: {contents[1*8 +: 2], contents[0*8 +: 8]},
    y_start: {contents[3*8 +: 2], contents[2*8 +: 8]},
    x_end:   {contents[5*8 +: 2], contents[4*8 +: 8]},
    y_end:   {contents[7*8 +: 2], contents[6*8 +: 8]}
  };

  // Span checks in displayed-image terms; rotation and resizing are not applied here.
  wire logic [1:0] next_status = {next_window.y_end >= next_window.y_start,
                                  next_window.x_end >= next_window.x_start};

  // The rectangle leaves through flops so downstream timing starts clean.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      window    <= '0;
      status    <= '0;
      window_ok <= 1'b0;
    end else begin
      window    <= next_window;
      status    <= next_status;
      window_ok <= &next_status;
    end
  end

  // ----------------------------------------------------------------------
  // Write channel.
  // ----------------------------------------------------------------------

  // Address and data are caught in either order, then written together.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_state <= dwc_pkg::WR_COLLECT;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= '0;
      wr_byte  <= dwc_pkg::BYTE_RESET;
      wr_lane0 <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= dwc_pkg::RESP_OKAY;
    end else begin
      case (wr_state)
        dwc_pkg::WR_COLLECT: begin
          if (aw_take) begin
            aw_held <= 1'b1;
            wr_addr <= awaddr;
          end
          if (w_take) begin
            w_held   <= 1'b1;
            wr_byte  <= wdata[7:0];
            wr_lane0 <= wstrb[0];
          end
          awready <= !(aw_held || aw_take);
          wready  <= !(w_held || w_take);
          if (wr_fire) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= (wr_hit || wr_stat) ? dwc_pkg::RESP_OKAY : dwc_pkg::RESP_SLVERR;
            wr_state <= dwc_pkg::WR_RESP;
          end
        end
        dwc_pkg::WR_RESP: begin
          if (bready) begin
            bvalid   <= 1'b0;
            awready  <= 1'b1;
            wready   <= 1'b1;
            wr_state <= dwc_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state <= dwc_pkg::WR_COLLECT;
          bvalid   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read channel.
  // ----------------------------------------------------------------------

  // The store answers one cycle after the address, hence the fetch state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_state <= dwc_pkg::RD_IDLE;
      rd_addr  <= '0;
      arready  <= 1'b0;
      rvalid   <= 1'b0;
      rdata    <= '0;
      rresp    <= dwc_pkg::RESP_OKAY;
    end else begin
      case (rd_state)
        dwc_pkg::RD_IDLE: begin
          arready <= 1'b1;
          if (ar_take) begin
            rd_addr  <= araddr;
            arready  <= 1'b0;
            rd_state <= dwc_pkg::RD_FETCH;
          end
        end
        dwc_pkg::RD_FETCH: begin
          rvalid   <= 1'b1;
          rd_state <= dwc_pkg::RD_RESP;
          if (rd_hit) begin
            rdata <= {24'h00_0000, store_rd};
            rresp <= dwc_pkg::RESP_OKAY;
          end else if (rd_stat) begin
            rdata <= {30'h0000_0000, status};
            rresp <= dwc_pkg::RESP_OKAY;
          end else begin
            rdata <= '0;
            rresp <= dwc_pkg::RESP_SLVERR;
          end
        end
        dwc_pkg::RD_RESP: begin
          if (rready) begin
            rvalid   <= 1'b0;
            arready  <= 1'b1;
            rd_state <= dwc_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state <= dwc_pkg::RD_IDLE;
          rvalid   <= 1'b0;
        end
      endcase
    end
  end

endmodule // dwc_regs

/* pkg/dwc_pkg.sv */
// Package holding constants and types of the display window coordinate register bank.
package dwc_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address of each is four times its index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_X_START_LOW  = 8'h38;
  localparam logic [7:0] IDX_X_START_HIGH = 8'h3a;
  localparam logic [7:0] IDX_Y_START_LOW  = 8'h3c;
  localparam logic [7:0] IDX_Y_START_HIGH = 8'h3e;
  localparam logic [7:0] IDX_X_END_LOW    = 8'h40;
  localparam logic [7:0] IDX_X_END_HIGH   = 8'h42;
  localparam logic [7:0] IDX_Y_END_LOW    = 8'h44;
  localparam logic [7:0] IDX_Y_END_HIGH   = 8'h46;
  localparam logic [7:0] IDX_STATUS       = 8'h47;

  // ----------------------------------------------------------------------
  // Field layout and reset values.
  // ----------------------------------------------------------------------
  localparam int         COORD_W       = 10;
  localparam int         LOW_W         = 8;
  localparam int         HIGH_W        = 2;
  localparam int         SLOT_N        = 8;
  localparam int         SLOT_W        = 3;
  localparam int         ADDR_W        = 12;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [7:0] HIGH_MASK     = 8'h03;
  localparam int         STAT_X_OK_BIT = 0;
  localparam int         STAT_Y_OK_BIT = 1;

  // ----------------------------------------------------------------------
  // Bus response codes.
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Write channel states.
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } dwc_wr_e;

  // Read channel states.
  typedef enum logic [2:0] {
    RD_IDLE  = 3'b001,
    RD_FETCH = 3'b010,
    RD_RESP  = 3'b100
  } dwc_rd_e;

  // The update window rectangle as the rest of the chip sees it.
  typedef struct packed {
    logic [COORD_W-1:0] x_start;
    logic [COORD_W-1:0] y_start;
    logic [COORD_W-1:0] x_end;
    logic [COORD_W-1:0] y_end;
  } dwc_window_s;

endpackage

/* core/dwc_store.sv */
// Small byte store holding the window coordinate register slots.
module dwc_store #(
  parameter int SLOT_N = 8,
  parameter int SLOT_W = 3,
  parameter int DATA_W = 8
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     wr_en,
  input  wire logic [SLOT_W-1:0]        wr_slot,
  input  wire logic [DATA_W-1:0]        wr_data,
  input  wire logic [SLOT_W-1:0]        rd_slot,
  output logic      [DATA_W-1:0]        rd_data,
  output logic      [SLOT_N*DATA_W-1:0] contents
);

  // ----------------------------------------------------------------------
  // Storage slots, each cleared by reset.
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SLOT_N; g = g + 1) begin : g_slot
      wire logic hit = wr_en && (wr_slot == SLOT_W'(g));
      // One slot; only a write that names it changes it.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          contents[g*DATA_W +: DATA_W] <= dwc_pkg::BYTE_RESET;
        end else if (hit) begin
          contents[g*DATA_W +: DATA_W] <= wr_data;
        end
      end
    end
  endgenerate

  // Read data leave through a register so the bus sees a clean value.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= dwc_pkg::BYTE_RESET;
    end else begin
      rd_data <= contents[rd_slot*DATA_W +: DATA_W];
    end
  end

endmodule // dwc_store

/* sim/dwc_regs_chk.sv */
// Checker of bus timing and window behaviour of the coordinate register bank.
module dwc_chk (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic [1:0]           bresp,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic [31:0]          rdata,
  input wire logic [1:0]           rresp,
  input wire logic                 rvalid,
  input wire dwc_pkg::dwc_window_s window
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // All checks share the one clock, and reset silences them.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_wr_latency: assert property (awvalid && awready && wvalid && wready |=>
    !bvalid ##1 bvalid) else $error("write response not on second edge");
  a_rd_latency: assert property (arvalid && arready |=> !rvalid ##1 rvalid)
    else $error("read data not on second edge");
  a_ar_drop: assert property (arvalid && arready |=> !arready)
    else $error("read address ready stayed high");
  a_ready_back: assert property (bvalid && bready |=> awready && wready)
    else $error("write readies did not return");
  a_rd_upper: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_err_zero: assert property (rvalid && rresp != dwc_pkg::RESP_OKAY |-> rdata == '0)
    else $error("refused read returned data");
  // A window move without a finished good write means a stray update.
  // The window moves one edge after the response rises, so look one edge back.
  a_window_cause: assert property ($changed(window) |-> $past(bvalid) &&
    $past(bresp) == dwc_pkg::RESP_OKAY) else $error("window moved without a write");
  a_reset_clear: assert property ($rose(nrst) |-> window == '0 && !bvalid && !rvalid)
    else $error("window not cleared by reset");
endmodule // dwc_chk

bind dwc_regs dwc_chk i_dwc_chk (.clk(clk), .nrst(nrst), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .window(window));

/* sim/dwc_regs_tb_top.sv */
// Testbench of the window coordinate register bank driven over its register bus.
module dwc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = dwc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = dwc_pkg::RESP_SLVERR;
  logic                 clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid, window_ok;
  logic [11:0]          awaddr, araddr;
  logic [31:0]          wdata, rdata;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp;
  dwc_pkg::dwc_window_s window;
  int                   bad_count, num_checks;
  logic [7:0]           idx [8];
  logic [31:0]          wval [8];
  logic [7:0]           rexp [8];

  dwc_regs i_dwc_regs (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .window(window), .window_ok(window_ok));

  // Free running clock of 10 ns.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The wr and rd tasks first let an edge pass, so no signal is assigned twice in one step.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    @(posedge clk);
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid && n < 100);
    bready <= 1'h0;
    chk("bvalid", bvalid, 1'h1);
    chk("bresp", bresp, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid && n < 100);
    rready <= 1'h0;
    chk("rvalid", rvalid, 1'h1);
    chk("rdata", rdata, e);
    chk("rresp", rresp, er);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  // High bytes except Y end's carry junk above bits 1-0 so that dropped bits are seen.
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    idx = '{dwc_pkg::IDX_X_START_LOW, dwc_pkg::IDX_X_START_HIGH, dwc_pkg::IDX_Y_START_LOW,
      dwc_pkg::IDX_Y_START_HIGH, dwc_pkg::IDX_X_END_LOW, dwc_pkg::IDX_X_END_HIGH,
      dwc_pkg::IDX_Y_END_LOW, dwc_pkg::IDX_Y_END_HIGH};
    wval = '{32'h0000_00a5, 32'hdead_befe, 32'h0000_003c, 32'hffff_ff01,
      32'h0000_005a, 32'h1234_5603, 32'h0000_00c3, 32'h0000_0002};
    rexp = '{8'ha5, 8'h02, 8'h3c, 8'h01, 8'h5a, 8'h03, 8'hc3, 8'h02};
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    for (int i = 0; i < 8; i++) rd(ba(idx[i]), 32'h0000_0000, OK);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(ba(idx[i]), wval[i], 4'hf, OK);
      rd(ba(idx[i]), {24'h00_0000, rexp[i]}, OK);
    end
    chk("window", window, {10'h2a5, 10'h13c, 10'h35a, 10'h2c3});
    chk("window_ok", window_ok, 1'h1);
    rd(ba(dwc_pkg::IDX_STATUS), 32'h0000_0003, OK);
    $display("test coordinates done");
    wr(ba(idx[0]), 32'h0000_0000, 4'h0, OK);
    rd(ba(idx[0]), 32'h0000_00a5, OK);
    wr(12'h004, 32'hffff_ffff, 4'hf, ER);
    rd(12'h004, 32'h0000_0000, ER);
    rd(ba(idx[0]) + 12'h001, 32'h0000_0000, ER);
    wr(ba(idx[5]), 32'h0000_0000, 4'hf, OK);
    wr(ba(idx[4]), 32'h0000_0000, 4'hf, OK);
    rd(ba(dwc_pkg::IDX_STATUS), 32'h0000_0002, OK);
    chk("window_x_end", window.x_end, 10'h000);
    chk("window_ok_low", window_ok, 1'h0);
    $display("test refusals done");
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("window_reset", window, 40'h00_0000_0000);
    nrst <= 1'h1;
    for (int i = 0; i < 8; i++) rd(ba(idx[i]), 32'h0000_0000, OK);
    $display("test mid reset done");
    final_report;
  end

  // Cuts a hang short; the whole run needs well under a tenth of this.
  initial begin
    #200000;
    bad_count++;
    final_report;
  end
endmodule // dwc_regs_tb_top
